// ===== logic/irq_map_defines.vh
`ifndef IRQ_MAP_DEFINES_VH
`define IRQ_MAP_DEFINES_VH

`define NUM_REQUESTS 24
`define REQ_IDX_W 5
`define LEVEL_W 2
`define ADDR_W 16
`define DATA_W 8
// vector table: request n has its upper byte at TOP - 2n, lower byte one above
`define VECTOR_TOP 16'hFFFA
`define REQ_EXT4 5'h00
`define REQ_EXT6 5'h02
`define REQ_TIMER0_LO 5'h05
`define REQ_TIMER0_HI 5'h06
`define LEVEL_RESET 2'h3
`define LEVEL_LOWEST 2'h3

`endif

// ===== logic/vector_fetch.v
`timescale 1ns/1ps
`include "irq_map_defines.vh"

// fetches the two vector bytes of one accepted request and assembles the entry point
module vector_fetch (
    input wire clock,
    input wire rst_n,
    input wire start,
    input wire [`REQ_IDX_W-1:0] req_index,
    output reg mem_rd,
    output reg [`ADDR_W-1:0] mem_addr,
    input wire [`DATA_W-1:0] mem_rdata,
    output reg done,
    output reg [2*`DATA_W-1:0] entry_point,
    output reg busy
);

    localparam ST_IDLE = 2'h0;
    localparam ST_HIGH = 2'h1;
    localparam ST_LOW = 2'h2;

    reg [1:0] state;
    wire [`ADDR_W-1:0] upper_addr;

    assign upper_addr = `VECTOR_TOP - {{(`ADDR_W-`REQ_IDX_W-1){1'b0}}, req_index, 1'b0};

    always @(posedge clock) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            mem_rd <= 1'b0;
            mem_addr <= {`ADDR_W{1'b0}};
            done <= 1'b0;
            entry_point <= {(2*`DATA_W){1'b0}};
            busy <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    mem_rd <= 1'b0;
                    if (start) begin
                        mem_rd <= 1'b1;
                        mem_addr <= upper_addr;
                        busy <= 1'b1;
                        state <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    entry_point[2*`DATA_W-1:`DATA_W] <= mem_rdata;
                    mem_addr <= mem_addr + 16'h0001;
                    state <= ST_LOW;
                end
                ST_LOW: begin
                    entry_point[`DATA_W-1:0] <= mem_rdata;
                    mem_rd <= 1'b0;
                    done <= 1'b1;
                    busy <= 1'b0;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // vector_fetch

// ===== logic/irq_vector_priority_map.v
// Operation
// - external channel 4 is request 0, vector FFFA/FFFB, highest priority among equal levels, level from its field
// - external channel 6 is request 2, vector FFF6/FFF7, level from its field
// - timer 0 lower-half interrupt is request 5, vector FFF0/FFF1
// - timer 0 upper-half interrupt is request 6, vector FFEE/FFEF
// - each request has its own two-bit level field
// - equal levels resolve by request number, 0 highest, 23 lowest
`timescale 1ns/1ps
`include "irq_map_defines.vh"

module irq_vector_priority_map #(
    parameter NREQ = `NUM_REQUESTS
) (
    input wire clock,
    input wire rst_n,
    input wire ext_int4,
    input wire ext_int6,
    input wire timer0_lower_int,
    input wire timer0_upper_int,
    input wire [NREQ-1:0] other_sources,
    input wire [2*NREQ-1:0] level_fields,
    input wire level_write,
    input wire [NREQ-1:0] pending_clear,
    input wire [1:0] cpu_level,
    input wire cpu_int_enable,
    input wire [`DATA_W-1:0] mem_rdata,
    output reg [NREQ-1:0] pending,
    output reg [2*NREQ-1:0] level_regs,
    output reg irq_accept,
    output reg [`REQ_IDX_W-1:0] accepted_index,
    output reg [`LEVEL_W-1:0] accepted_level,
    output reg vector_rd,
    output reg [`ADDR_W-1:0] vector_addr,
    output reg entry_valid,
    output reg [2*`DATA_W-1:0] entry_point
);

    reg [NREQ-1:0] sources;
    reg [`REQ_IDX_W-1:0] best_index;
    reg [`LEVEL_W-1:0] best_level;
    reg best_found;
    reg [`LEVEL_W-1:0] lvl;
    integer i;
    wire fetch_rd;
    wire [`ADDR_W-1:0] fetch_addr;
    wire fetch_done;
    wire [2*`DATA_W-1:0] fetch_entry;
    wire fetch_busy;

    // map named peripherals onto their fixed request numbers
    always @* begin
        sources = other_sources;
        sources[`REQ_EXT4] = ext_int4;
        sources[`REQ_EXT6] = ext_int6;
        sources[`REQ_TIMER0_LO] = timer0_lower_int;
        sources[`REQ_TIMER0_HI] = timer0_upper_int;
    end

    // fixed-order resolve
    // scan from the bottom so lower numbers overwrite on ties; non-strict <= lets the lower index win
    always @* begin
        best_found = 1'b0;
        best_index = {`REQ_IDX_W{1'b0}};
        best_level = `LEVEL_LOWEST;
        lvl = `LEVEL_LOWEST;
        for (i = NREQ - 1; i >= 0; i = i - 1) begin
            lvl = level_regs[2*i +: 2];
            if (pending[i] && (!best_found || lvl <= best_level)) begin
                best_found = 1'b1;
                best_index = i[`REQ_IDX_W-1:0];
                best_level = lvl;
            end
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            level_regs <= {NREQ{`LEVEL_RESET}};
        end else if (level_write) begin
            level_regs <= level_fields;
        end
    end

    // pending: a source event beats a clear in the same cycle
    always @(posedge clock) begin
        if (!rst_n) begin
            pending <= {NREQ{1'b0}};
        end else begin
            pending <= (pending & ~pending_clear
                        & ~({NREQ{irq_accept}} & ({{(NREQ-1){1'b0}}, 1'b1} << accepted_index)))
                       | sources;
        end
    end

    // accept only a level strictly more urgent than the cpu's current level (lower value)
    always @(posedge clock) begin
        if (!rst_n) begin
            irq_accept <= 1'b0;
            accepted_index <= {`REQ_IDX_W{1'b0}};
            accepted_level <= {`LEVEL_W{1'b0}};
        end else begin
            irq_accept <= 1'b0;
            if (best_found && cpu_int_enable && best_level < cpu_level && !fetch_busy && !irq_accept) begin
                irq_accept <= 1'b1;
                accepted_index <= best_index;
                accepted_level <= best_level;
            end
        end
    end

    vector_fetch fetch (
        .clock(clock),
        .rst_n(rst_n),
        .start(irq_accept),
        .req_index(accepted_index),
        .mem_rd(fetch_rd),
        .mem_addr(fetch_addr),
        .mem_rdata(mem_rdata),
        .done(fetch_done),
        .entry_point(fetch_entry),
        .busy(fetch_busy)
    );

    always @(posedge clock) begin
        if (!rst_n) begin
            vector_rd <= 1'b0;
            vector_addr <= {`ADDR_W{1'b0}};
            entry_valid <= 1'b0;
            entry_point <= {(2*`DATA_W){1'b0}};
        end else begin
            vector_rd <= fetch_rd;
            vector_addr <= fetch_addr;
            entry_valid <= fetch_done;
            if (fetch_done) begin
                entry_point <= fetch_entry;
            end
        end
    end

endmodule // irq_vector_priority_map

// ===== dv/vector_memory.sv
`timescale 1ns/1ps
module vector_memory (
    input wire clock,
    input wire irq_accept,
    input wire [4:0] accepted_index,
    output wire [7:0] mem_rdata
);
    reg [1:0] step = 2'h0;
    reg [7:0] idle = 8'h00;
    wire [7:0] lo = 8'hFA - {accepted_index, 1'b0};
    assign mem_rdata = step == 2'h1 ? lo : step == 2'h2 ? ~(lo + 8'h01) : idle;
    always @(posedge clock) begin
        // idle bus wanders so a stale capture shows
        idle <= idle + 8'h35;
        step <= irq_accept ? 2'h1 : (step == 2'h0 ? 2'h0 : step + 2'h1);
    end
endmodule // vector_memory

// ===== dv/irq_map_assertions.sv
`timescale 1ns/1ps
module irq_map_checker #(
    parameter NREQ = 24
) (
    input wire clock,
    input wire rst_n,
    input wire ext_int4,
    input wire ext_int6,
    input wire timer0_lower_int,
    input wire timer0_upper_int,
    input wire [2*NREQ-1:0] level_fields,
    input wire level_write,
    input wire [NREQ-1:0] pending,
    input wire [2*NREQ-1:0] level_regs,
    input wire irq_accept,
    input wire [4:0] accepted_index,
    input wire [1:0] accepted_level,
    input wire vector_rd,
    input wire [15:0] vector_addr,
    input wire entry_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire [15:0] up = 16'hFFFA - {accepted_index, 1'b0};
    ext4_set_a: assert property (ext_int4 |=> pending[0]) else $error("ext4 lost");
    ext6_set_a: assert property (ext_int6 |=> pending[2]) else $error("ext6 lost");
    tlo_set_a: assert property (timer0_lower_int |=> pending[5]) else $error("tlo lost");
    thi_set_a: assert property (timer0_upper_int |=> pending[6]) else $error("thi lost");
    level_load_a: assert property (level_write |=> level_regs == $past(level_fields)) else $error("lvl");
    // request 0 pending at a level no worse than the winner's must itself be the winner
    top_prio_a: assert property (irq_accept && $past(pending[0]) && $past(level_regs[1:0]) <= accepted_level
        |-> accepted_index == 5'h00) else $error("prio");
    vec_high_a: assert property (irq_accept |-> ##2 vector_rd && vector_addr == up) else $error("hi");
    vec_low_a: assert property (irq_accept |-> ##3 vector_addr == up + 16'h0001) else $error("lo");
    entry_time_a: assert property (irq_accept |-> ##4 entry_valid) else $error("entry");
    cover property (irq_accept && accepted_index == 5'h17);
    cover property (entry_valid);
    cover property (level_write);
endmodule // irq_map_checker

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [3:0] named = 4'h0;
    reg [23:0] other = 24'h000000;
    reg [47:0] lf = 48'h000000000000;
    reg lw = 1'b0;
    reg [1:0] cpu_level = 2'h3;
    wire [23:0] pending;
    wire [47:0] level_regs;
    wire irq_accept, vector_rd, entry_valid;
    wire [4:0] accepted_index;
    wire [15:0] vector_addr, entry_point;
    wire [7:0] mem_rdata;
    integer n_errors = 0, tests_run = 0, cycles = 0, i;
    initial forever #20 clock = ~clock;
    irq_vector_priority_map u_irq_vector_priority_map (.clock(clock), .rst_n(rst_n), .ext_int4(named[0]),
        .ext_int6(named[1]), .timer0_lower_int(named[2]), .timer0_upper_int(named[3]), .other_sources(other),
        .level_fields(lf), .level_write(lw), .pending_clear(24'h000000), .cpu_level(cpu_level),
        .cpu_int_enable(1'b1), .mem_rdata(mem_rdata), .pending(pending), .level_regs(level_regs),
        .irq_accept(irq_accept), .accepted_index(accepted_index), .accepted_level(), .vector_rd(vector_rd),
        .vector_addr(vector_addr), .entry_valid(entry_valid), .entry_point(entry_point));
    vector_memory u_vector_memory (.clock(clock), .irq_accept(irq_accept), .accepted_index(accepted_index),
        .mem_rdata(mem_rdata));
    task chk(input string what, input [47:0] exp, input [47:0] got);
        begin
            tests_run = tests_run + 1;
            if (exp !== got) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %s exp %h got %h", what, exp, got);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_errors);
            if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task pulse(input [3:0] n, input [23:0] o);
        begin
            named = n;
            other = o;
            @(negedge clock);
            named = 4'h0;
            other = 24'h000000;
        end
    endtask
    task wlev(input [47:0] v);
        begin
            lf = v;
            lw = 1'b1;
            @(negedge clock);
            lw = 1'b0;
            chk("levels", v, level_regs);
        end
    endtask
    task serve(input [4:0] idx);
        reg [7:0] lo;
        integer k;
        begin
            lo = 8'hFA - {idx, 1'b0};
            for (k = 0; k < 40 && irq_accept !== 1'b1; k = k + 1) @(negedge clock);
            chk("index", idx, accepted_index);
            repeat (4) @(negedge clock);
            chk("valid", 1'b1, entry_valid);
            chk("entry", {lo, ~(lo + 8'h01)}, entry_point);
        end
    endtask
    task t_level;
        begin
            chk("reset levels", {24{2'h3}}, level_regs);
            wlev({{18{2'h1}}, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1});
            pulse(4'h6, 24'h000000);
            serve(5'h05);
            serve(5'h02);
            $display("level test done");
        end
    endtask
    task t_named;
        begin
            wlev({24{2'h1}});
            for (i = 0; i < 4; i = i + 1) begin
                pulse(4'h1 << i, 24'h000000);
                serve(i < 2 ? 2 * i : i + 3);
            end
            pulse(4'h3, 24'h800000);
            serve(5'h00);
            serve(5'h02);
            serve(5'h17);
            $display("named and tie test done");
        end
    endtask
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    initial begin
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        t_level;
        t_named;
        test_done;
    end
endmodule // tb
bind irq_vector_priority_map irq_map_checker #(.NREQ(24)) u_irq_map_checker (.clock, .rst_n, .ext_int4,
    .ext_int6, .timer0_lower_int, .timer0_upper_int, .level_fields, .level_write, .pending, .level_regs,
    .irq_accept, .accepted_index, .accepted_level, .vector_rd, .vector_addr, .entry_valid);
